/* src/bcd_boot_config.sv */
// boot configuration byte decoder: samples the store at reset and applies it
`timescale 1ns/1ps
module bcd_boot_config (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // configuration store contents
  input wire logic [7:0] boot_option_store,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // decoded settings
  output logic double_speed_select,
  output logic crystal_oscillator,
  output logic precision_rc_oscillator,
  output logic low_power_rc_oscillator,
  output logic crystal_clock_in_enable,
  output logic [3:0] prescaler_reload,
  output logic programmer_read_block,
  output logic osc_select_reserved,
  // clock output port line, open drain
  output logic clock_output_port_line_o,
  output logic clock_output_port_line_oe,
  // core clock enable
  output logic core_clock_out
);
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  bcd_pkg::bcd_state_e state;
  bcd_pkg::bcd_state_e next_state;
  logic [2:0] hold_cnt;
  logic [2:0] next_hold_cnt;
  logic [1:0] div3;
  logic [1:0] next_div3;
  logic [7:0] next_rdata;
  logic next_pin_o;
  logic next_pin_oe;
  logic [1:0] osc_sel;
  logic core_en;
  logic unused_wr;

  // writes are ignored: the store is read-only to software
  assign unused_wr = reg_wr ^ (|reg_wdata);
  assign osc_sel = {cfg[bcd_pkg::BCD_BIT_OSC_HI], cfg[bcd_pkg::BCD_BIT_OSC_LO]};

  always_comb begin
    next_cfg = cfg;
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      bcd_pkg::BCD_RESET: begin
        next_state = bcd_pkg::BCD_HOLD;
        next_hold_cnt = 3'h0;
      end
      bcd_pkg::BCD_HOLD: begin
        if (hold_cnt == 3'(bcd_pkg::BCD_HOLD_CYCLES - 1)) begin
          next_state = bcd_pkg::BCD_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 3'h1;
        end
      end
      bcd_pkg::BCD_RUN: begin
        next_state = bcd_pkg::BCD_RUN;
      end
      default: begin
        next_state = bcd_pkg::BCD_RESET;
      end
    endcase
  end

  // byte captured while reset is asserted, frozen afterwards
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= boot_option_store;
      state <= bcd_pkg::BCD_RESET;
      hold_cnt <= 3'h0;
    end else begin
      cfg <= next_cfg;
      state <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // decoded settings, registered so every output comes from a flop
  logic next_double;
  logic next_xtal;
  logic next_prc;
  logic next_lprc;
  logic [3:0] next_presc;
  logic next_lock;
  logic next_rsvd;

  always_comb begin
    next_double = cfg[bcd_pkg::BCD_BIT_DOUBLE];
    next_xtal = (osc_sel == bcd_pkg::BCD_OSC_CRYSTAL);
    next_prc = (osc_sel == bcd_pkg::BCD_OSC_PRECISION);
    next_lprc = (osc_sel == bcd_pkg::BCD_OSC_LOWPOWER);
    next_rsvd = (osc_sel == 2'h0);
    next_presc = cfg[bcd_pkg::BCD_BIT_PRESC_INIT] ? bcd_pkg::BCD_PRESC_SET
                                                    : bcd_pkg::BCD_PRESC_CLR;
    // level 3: upper programmed (0), lower unprogrammed (1)
    next_lock = !cfg[bcd_pkg::BCD_BIT_LOCK_HI] && cfg[bcd_pkg::BCD_BIT_LOCK_LO];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      double_speed_select <= 1'b1;
      crystal_oscillator <= 1'b1;
      precision_rc_oscillator <= 1'b0;
      low_power_rc_oscillator <= 1'b0;
      osc_select_reserved <= 1'b0;
      crystal_clock_in_enable <= 1'b1;
      prescaler_reload <= bcd_pkg::BCD_PRESC_CLR;
      // locked until the real byte is decoded, so reset never opens a read window
      programmer_read_block <= 1'b1;
    end else begin
      double_speed_select <= next_double;
      crystal_oscillator <= next_xtal;
      precision_rc_oscillator <= next_prc;
      low_power_rc_oscillator <= next_lprc;
      osc_select_reserved <= next_rsvd;
      crystal_clock_in_enable <= 1'b1;
      prescaler_reload <= next_presc;
      programmer_read_block <= next_lock;
    end
  end

  // any one oscillator runs the divider; reserved code leaves the core stopped
  bcd_clock_divider u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .osc_en(state == bcd_pkg::BCD_RUN && !osc_select_reserved),
    .double_speed_select(double_speed_select),
    .prescaler_reload(prescaler_reload),
    .core_en(core_en)
  );

  // clock-output on the port line: low while starting, then core/3 one-third high
  always_comb begin
    next_div3 = div3;
    next_pin_o = 1'b0;
    next_pin_oe = 1'b0;
    if (!cfg[bcd_pkg::BCD_BIT_CLKOUT_N]) begin
      next_pin_oe = 1'b1;
      if (state == bcd_pkg::BCD_RUN) begin
        if (core_en) begin
          next_div3 = (div3 == bcd_pkg::BCD_CLKOUT_DIV - 2'h1) ? 2'h0 : div3 + 2'h1;
        end
        // drive low for two thirds, release high for one third
        next_pin_oe = (div3 >= bcd_pkg::BCD_CLKOUT_HIGH);
      end
    end else begin
      next_pin_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div3 <= 2'h0;
      clock_output_port_line_o <= 1'b0;
      clock_output_port_line_oe <= 1'b0;
      core_clock_out <= 1'b0;
    end else begin
      div3 <= next_div3;
      clock_output_port_line_o <= next_pin_o;
      clock_output_port_line_oe <= next_pin_oe;
      core_clock_out <= core_en;
    end
  end

  // read port: one byte, data the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd && reg_addr == bcd_pkg::BCD_CONFIG_ADDR) begin
      next_rdata = cfg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

/* src/bcd_clock_divider.sv */
// core clock enable from the oscillator enable, direct or divided by 2*(16-m)
`timescale 1ns/1ps
module bcd_clock_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control
  input wire logic osc_en,
  input wire logic double_speed_select,
  input wire logic [3:0] prescaler_reload,
  // result
  output logic core_en
);
  logic [4:0] count;
  logic [4:0] next_count;
  logic next_core_en;
  logic [4:0] half;

  always_comb begin
    half = {1'b0, bcd_pkg::BCD_PRESC_TOP} + 5'h01 - {1'b0, prescaler_reload};
    next_count = count;
    next_core_en = 1'b0;
    if (osc_en) begin
      if (!double_speed_select) begin
        next_core_en = 1'b1;
        next_count = 5'h00;
      end else if (count >= 5'(({1'b0, half} << 1) - 6'h01)) begin
        next_core_en = 1'b1;
        next_count = 5'h00;
      end else begin
        next_count = count + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= 5'h00;
      core_en <= 1'b0;
    end else begin
      count <= next_count;
      core_en <= next_core_en;
    end
  end
endmodule

/* src/bcd_pkg.sv */
// constants for the boot configuration byte decoder
package bcd_pkg;
  localparam logic [7:0] BCD_CONFIG_ADDR = 8'hef;
  localparam int BCD_CODE_ARRAY_BYTES = 4096;
  localparam logic [7:0] BCD_CONFIG_DEFAULT = 8'hff;
  localparam int BCD_BIT_DOUBLE = 7;
  localparam int BCD_BIT_OSC_HI = 6;
  localparam int BCD_BIT_OSC_LO = 5;
  localparam int BCD_BIT_CLKOUT_N = 4;
  localparam int BCD_BIT_PRESC_INIT = 3;
  localparam int BCD_BIT_LOCK_HI = 1;
  localparam int BCD_BIT_LOCK_LO = 0;
  localparam logic [1:0] BCD_OSC_CRYSTAL = 2'h3;
  localparam logic [1:0] BCD_OSC_PRECISION = 2'h2;
  localparam logic [1:0] BCD_OSC_LOWPOWER = 2'h1;
  localparam logic [3:0] BCD_PRESC_SET = 4'h8;
  localparam logic [3:0] BCD_PRESC_CLR = 4'hf;
  localparam logic [3:0] BCD_PRESC_TOP = 4'hf;
  localparam logic [1:0] BCD_CLKOUT_DIV = 2'h3;
  localparam logic [1:0] BCD_CLKOUT_HIGH = 2'h1;
  localparam int BCD_HOLD_CYCLES = 4;
  typedef enum logic [1:0] {BCD_RESET, BCD_HOLD, BCD_RUN} bcd_state_e;
endpackage

/* verification/bcd_boot_config_assertions.sv */
// port assertions for the boot configuration decoder
`timescale 1ns/1ps
module bcd_boot_config_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // store and register port
  input wire logic [7:0] boot_option_store,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // decoded settings
  input wire logic double_speed_select,
  input wire logic crystal_oscillator,
  input wire logic precision_rc_oscillator,
  input wire logic low_power_rc_oscillator,
  input wire logic osc_select_reserved,
  input wire logic crystal_clock_in_enable,
  input wire logic [3:0] prescaler_reload,
  input wire logic programmer_read_block,
  // clock output and core enable
  input wire logic clock_output_port_line_o,
  input wire logic clock_output_port_line_oe,
  input wire logic core_clock_out
);
  logic [7:0] cfg, next_cfg;
  logic [3:0] run, next_run;
  logic [3:0] osc;
  // run saturates so the long-term checks start well inside the run phase
  always_comb begin
    next_cfg = srst ? boot_option_store : cfg;
    next_run = srst ? 4'h0 : (run == 4'hf ? run : run + 4'h1);
  end
  always_ff @(posedge sys_clk) begin
    cfg <= next_cfg;
    run <= next_run;
  end
  assign osc = {crystal_oscillator, precision_rc_oscillator, low_power_rc_oscillator, osc_select_reserved};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_xtal_kept: assert property (crystal_clock_in_enable) else $error("crystal input off");
  chk_osc_decode: assert property (run != 0 |-> osc == {cfg[6:5] == 2'h3, cfg[6:5] == 2'h2,
    cfg[6:5] == 2'h1, cfg[6:5] == 2'h0}) else $error("oscillator decode wrong");
  chk_clock_mode: assert property (run != 0 |-> double_speed_select == cfg[7] &&
    prescaler_reload == (cfg[3] ? 4'h8 : 4'hf)) else $error("clock mode wrong");
  chk_lock_level: assert property (run != 0 |-> programmer_read_block == (cfg[1:0] == 2'h1))
    else $error("lock decode wrong");
  chk_settings_hold: assert property (run != 0 |=> $stable({osc, double_speed_select, prescaler_reload,
    programmer_read_block})) else $error("settings moved");
  chk_read_data: assert property (reg_rd && reg_addr == 8'hef |=> reg_rdata == cfg)
    else $error("read data wrong");
  chk_read_idle: assert property (!(reg_rd && reg_addr == 8'hef) |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  chk_line_low: assert property (!cfg[4] && run inside {[1:4]} |-> clock_output_port_line_oe)
    else $error("line not held low");
  chk_drive_low: assert property (!clock_output_port_line_o) else $error("line driven high");
  chk_no_clkout: assert property (cfg[4] |-> !clock_output_port_line_oe) else $error("line driven");
  chk_clkout_third: assert property (!cfg[4] && !cfg[7] && cfg[6:5] != 0 && run == 4'hf &&
    !clock_output_port_line_oe |=> clock_output_port_line_oe [*2] ##1 !clock_output_port_line_oe)
    else $error("clock out shape wrong");
  chk_core_direct: assert property (!cfg[7] && cfg[6:5] != 0 && run == 4'hf |-> core_clock_out)
    else $error("core pulse missing");
  chk_core_stop: assert property (run != 0 && cfg[6:5] == 2'h0 |-> !core_clock_out)
    else $error("core runs on reserved");
endmodule
bind bcd_boot_config bcd_boot_config_assertions u_chk (.sys_clk, .srst, .boot_option_store, .reg_addr,
  .reg_rd, .reg_rdata, .double_speed_select, .crystal_oscillator, .precision_rc_oscillator,
  .low_power_rc_oscillator, .osc_select_reserved, .crystal_clock_in_enable, .prescaler_reload,
  .programmer_read_block, .clock_output_port_line_o, .clock_output_port_line_oe, .core_clock_out);

/* verification/tb.sv */
// self-checking bench for the boot configuration decoder
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pend = 1'b0;
  logic [7:0] boot_option_store = 8'hff, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, b;
  logic dss, xo, po, lo, xe, blk, res, oe, od, core;
  logic [3:0] presc;
  logic [7:0] corner [5] = '{8'hff, 8'h00, 8'h6f, 8'hc9, 8'ha6};
  int errors = 0, checked = 0, seed = 32'h9bf4, pulses, highs;
  always #10 sys_clk = ~sys_clk;
  bcd_boot_config u_dut (.sys_clk(sys_clk), .srst(srst), .boot_option_store(boot_option_store),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .double_speed_select(dss), .crystal_oscillator(xo), .precision_rc_oscillator(po),
    .low_power_rc_oscillator(lo), .crystal_clock_in_enable(xe), .prescaler_reload(presc),
    .programmer_read_block(blk), .osc_select_reserved(res), .clock_output_port_line_o(od),
    .clock_output_port_line_oe(oe), .core_clock_out(core));
  function automatic logic [10:0] exp_dec(input logic [7:0] v);
    return {v[7], v[6:5] == 2'h3, v[6:5] == 2'h2, v[6:5] == 2'h1, v[6:5] == 2'h0, 1'b1,
      v[3] ? 4'h8 : 4'hf, v[1:0] == 2'h1};
  endfunction
  // core pulses over a 48-cycle window
  function automatic int exp_pulses(input logic [7:0] v);
    return v[6:5] == 2'h0 ? 0 : !v[7] ? 48 : v[3] ? 3 : 24;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // random reads, writes and store changes; the store is only held while in reset
  task automatic cyc(input int n, input logic rst);
    logic r;
    repeat (n) begin
      @(posedge sys_clk);
      // request sampled at this edge; its answer stands just after it
      pend = reg_rd && reg_addr == 8'hef;
      r = !rst & 1'($random(seed));
      srst <= rst;
      reg_rd <= r;
      reg_wr <= !rst & !r & 1'($random(seed));
      reg_wdata <= 8'($random(seed));
      reg_addr <= 1'($random(seed)) ? 8'hef : 8'($random(seed));
      boot_option_store <= rst ? b : 8'($random(seed));
      #1;
      if (!srst) chk(16'(reg_rdata), pend ? 16'(b) : 16'h0, "rdata");
      pulses += core;
      highs += oe;
    end
  endtask
  initial begin
    for (int i = 0; i < 24; i++) begin
      b = i < 5 ? corner[i] : 8'($random(seed));
      cyc(4, 1'b1);
      cyc(8, 1'b0);
      pulses = 0;
      highs = 0;
      cyc(48, 1'b0);
      chk(16'({dss, xo, po, lo, res, xe, presc, blk}), 16'(exp_dec(b)), "decode");
      chk(16'(pulses), 16'(exp_pulses(b)), "core pulses");
      if (b[4] || b[6:5] != 2'h0) chk(16'(highs), b[4] ? 16'h0 : 16'h20, "clock out");
    end
    end_of_test;
  end
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule
